// ===== fvr_sequencer.sv
// Erase-verify section, read-once and phrase program command sequencer
`timescale 1ns/1ps
`include "fvr_regs.svh"

module fvr_sequencer
  import fvr_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash array port
  output logic             arr_req,
  output fvr_op_t          arr_op,
  output logic [23:0]      arr_addr,
  output logic [63:0]      arr_wdata,
  input  wire logic        arr_ack,
  input  wire logic [63:0] arr_rdata,
  input  wire logic        arr_rd_err,
  input  wire logic        arr_rd_noncorr,
  // Program flash read guard
  output logic             pflash_read_invalid
);

  fvr_param_if pif ();

  fvr_param_bank u_bank (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pif     (pif)
  );

  fvr_state_t  state_reg;
  logic        command_complete_flag;
  logic        access_error_flag;
  logic        protection_violation_flag;
  logic        error_status_bit;
  logic        uncorrectable_status_bit;
  logic [2:0]  parameter_word_index;
  logic [2:0]  launch_index_reg;
  logic [3:0]  cfg_reg;
  logic [17:0] prot_lo_reg;
  logic [17:0] prot_hi_reg;
  logic [15:0] remain_reg;
  logic [63:0] pg_data_reg;

  logic        acc_setup;
  logic        acc_access;
  logic        wr_en;
  logic        mapped;
  logic        launch;
  logic        clr_acc;
  logic        clr_fpv;
  logic [7:0]  cmd_code;
  logic [23:0] gaddr;
  logic [24:0] sec_end;
  logic        chk_acc;
  logic        chk_fpv;
  logic        addr_bad;
  logic        set_err;
  logic        set_unc;
  logic        rd_done;

  // APB decode; the slave never inserts wait states
  assign acc_setup  = psel && !penable;
  assign acc_access = psel && penable;
  assign pready     = 1'b1;
  assign mapped     = paddr == `FVR_STAT_OFS || paddr == `FVR_INDEX_OFS ||
                      paddr == `FVR_WORD_OFS || paddr == `FVR_CFG_OFS ||
                      paddr == `FVR_PROT_LO_OFS || paddr == `FVR_PROT_HI_OFS;
  assign pslverr    = acc_access && !mapped;
  assign wr_en      = acc_access && pwrite && mapped;

  assign launch  = wr_en && paddr == `FVR_STAT_OFS &&
                   pwdata[`FVR_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag;
  assign clr_acc = wr_en && paddr == `FVR_STAT_OFS &&
                   pwdata[`FVR_ACCESS_ERROR_FLAG_BIT];
  assign clr_fpv = wr_en && paddr == `FVR_STAT_OFS &&
                   pwdata[`FVR_PROTECTION_VIOLATION_FLAG_BIT];

  // Parameter words frozen to software writes while a command runs
  assign pif.sw_we    = wr_en && paddr == `FVR_WORD_OFS &&
                        command_complete_flag &&
                        parameter_word_index < 3'(`FVR_WORDS);
  assign pif.sw_idx   = parameter_word_index;
  assign pif.sw_wdata = pwdata[15:0];

  assign cmd_code = pif.words[0][15:8];
  assign gaddr    = {pif.words[0][7:0], pif.words[1]};
  // last byte of section plus one
  assign sec_end  = {1'b0, gaddr} + {6'h00, pif.words[2], 3'b000};
  assign addr_bad = gaddr < `FVR_PF_FIRST;

  // Launch-time checks
  always_comb begin
    chk_acc = 1'b0;
    chk_fpv = 1'b0;
    unique case (cmd_code)
      `FVR_CMD_EVSEC: begin
        if (launch_index_reg != `FVR_IX_EVSEC) chk_acc = 1'b1;
        if (!cfg_reg[`FVR_CFG_EV_BIT]) chk_acc = 1'b1;
        if (addr_bad) chk_acc = 1'b1;
        if (gaddr[2:0] != 3'b000) chk_acc = 1'b1;
        if (sec_end > `FVR_PF_END) chk_acc = 1'b1;
      end
      `FVR_CMD_RDONCE: begin
        if (launch_index_reg != `FVR_IX_RDONCE) chk_acc = 1'b1;
        if (!cfg_reg[`FVR_CFG_RO_BIT]) chk_acc = 1'b1;
        if (pif.words[1] > `FVR_ONCE_MAX) chk_acc = 1'b1;
      end
      `FVR_CMD_PGM: begin
        if (launch_index_reg != `FVR_IX_PGM) chk_acc = 1'b1;
        if (!cfg_reg[`FVR_CFG_PG_BIT]) chk_acc = 1'b1;
        if (addr_bad) chk_acc = 1'b1;
        if (gaddr[2:0] != 3'b000) chk_acc = 1'b1;
        if (cfg_reg[`FVR_CFG_PEN_BIT] && gaddr[17:0] >= prot_lo_reg &&
            gaddr[17:0] <= prot_hi_reg) chk_fpv = 1'b1;
      end
      default: begin
        // Unknown command codes are refused as well
        chk_acc = 1'b1;
      end
    endcase
  end

  assign rd_done = arr_req && arr_ack;
  always_comb begin
    set_err = 1'b0;
    set_unc = 1'b0;
    if (rd_done) begin
      unique case (state_reg)
        FVR_EV_RD: begin
          set_err = arr_rd_err || arr_rdata != `FVR_ERASED;
          set_unc = arr_rd_noncorr || arr_rdata != `FVR_ERASED;
        end
        FVR_RO_RD: begin
          set_err = arr_rd_err;
          set_unc = arr_rd_noncorr;
        end
        FVR_PG_VF: begin
          // Mismatch is treated as an uncorrectable verify error
          set_err = arr_rd_err || arr_rdata != pg_data_reg;
          set_unc = arr_rd_noncorr || arr_rdata != pg_data_reg;
        end
        default: begin
          set_err = 1'b0;
          set_unc = 1'b0;
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= FVR_IDLE;
    end else begin
      unique case (state_reg)
        FVR_IDLE:  if (launch) state_reg <= FVR_CHECK;
        FVR_CHECK: begin
          if (chk_acc || chk_fpv) state_reg <= FVR_DONE;
          else if (cmd_code == `FVR_CMD_RDONCE) state_reg <= FVR_RO_RD;
          else if (cmd_code == `FVR_CMD_PGM) state_reg <= FVR_PG_WR;
          else if (pif.words[2] == 16'h0000) state_reg <= FVR_DONE;
          else state_reg <= FVR_EV_RD;
        end
        FVR_EV_RD: begin
          if (rd_done && remain_reg == 16'h0001) state_reg <= FVR_DONE;
        end
        FVR_RO_RD: if (rd_done) state_reg <= FVR_DONE;
        FVR_PG_WR: if (rd_done) state_reg <= FVR_PG_VF;
        FVR_PG_VF: if (rd_done) state_reg <= FVR_DONE;
        FVR_DONE:  state_reg <= FVR_IDLE;
        default:   state_reg <= FVR_IDLE;
      endcase
    end
  end

  // Completion flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      command_complete_flag <= 1'b1;
    end else if (launch) begin
      command_complete_flag <= 1'b0;
    end else if (state_reg == FVR_DONE) begin
      command_complete_flag <= 1'b1;
    end
  end

  // Error flags; a hardware set wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      access_error_flag <= (access_error_flag && !clr_acc) ||
                           (state_reg == FVR_CHECK && chk_acc);
      protection_violation_flag <= (protection_violation_flag && !clr_fpv) ||
                                   (state_reg == FVR_CHECK && chk_fpv);
    end
  end

  // Result bits, cleared at each launch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      error_status_bit         <= 1'b0;
      uncorrectable_status_bit <= 1'b0;
    end else if (launch) begin
      error_status_bit         <= 1'b0;
      uncorrectable_status_bit <= 1'b0;
    end else begin
      if (set_err) error_status_bit <= 1'b1;
      if (set_unc) uncorrectable_status_bit <= 1'b1;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      parameter_word_index <= 3'h0;
      cfg_reg              <= `FVR_CFG_RST;
      prot_lo_reg          <= 18'h00000;
      prot_hi_reg          <= 18'h00000;
    end else if (wr_en && command_complete_flag) begin
      if (paddr == `FVR_INDEX_OFS) parameter_word_index <= pwdata[2:0];
      if (paddr == `FVR_CFG_OFS) cfg_reg <= pwdata[3:0];
      if (paddr == `FVR_PROT_LO_OFS) prot_lo_reg <= pwdata[17:0];
      if (paddr == `FVR_PROT_HI_OFS) prot_hi_reg <= pwdata[17:0];
    end
  end

  // Index as it stood at launch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      launch_index_reg <= 3'h0;
    end else if (launch) begin
      launch_index_reg <= parameter_word_index;
    end
  end

  // Array request, address and data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arr_req     <= 1'b0;
      arr_op      <= FVR_OP_READ;
      arr_addr    <= 24'h000000;
      arr_wdata   <= 64'h0000_0000_0000_0000;
      pg_data_reg <= 64'h0000_0000_0000_0000;
      remain_reg  <= 16'h0000;
    end else if (state_reg == FVR_CHECK && !chk_acc && !chk_fpv) begin
      remain_reg  <= pif.words[2];
      pg_data_reg <= {pif.words[2], pif.words[3],
                      pif.words[4], pif.words[5]};
      arr_wdata   <= {pif.words[2], pif.words[3],
                      pif.words[4], pif.words[5]};
      if (cmd_code == `FVR_CMD_RDONCE) begin
        arr_op   <= FVR_OP_ONCE;
        arr_addr <= {18'h00000, pif.words[1][2:0], 3'b000};
        arr_req  <= 1'b1;
      end else if (cmd_code == `FVR_CMD_PGM) begin
        arr_op   <= FVR_OP_PROG;
        arr_addr <= gaddr;
        arr_req  <= 1'b1;
      end else begin
        arr_op   <= FVR_OP_READ;
        arr_addr <= gaddr;
        arr_req  <= pif.words[2] != 16'h0000;
      end
    end else if (rd_done) begin
      unique case (state_reg)
        FVR_EV_RD: begin
          remain_reg <= remain_reg - 16'h0001;
          arr_addr   <= arr_addr + 24'h000008;
          arr_req    <= remain_reg != 16'h0001;
        end
        FVR_PG_WR: begin
          arr_op  <= FVR_OP_READ;
          arr_req <= 1'b1;
        end
        default: arr_req <= 1'b0;
      endcase
    end
  end

  // once-phrase into words 2 to 5
  logic [1:0] ro_slot;
  always_comb begin
    ro_slot = 2'd0;
    if (arr_req && arr_ack && state_reg == FVR_RO_RD) ro_slot = 2'd0;
  end

  logic       ro_wb_reg;
  logic [2:0] ro_wb_idx;
  logic [63:0] ro_data_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ro_wb_reg   <= 1'b0;
      ro_wb_idx   <= 3'h2;
      ro_data_reg <= 64'h0000_0000_0000_0000;
    end else if (state_reg == FVR_RO_RD && rd_done) begin
      ro_wb_reg   <= 1'b1;
      ro_wb_idx   <= 3'h2;
      ro_data_reg <= arr_rdata;
    end else if (ro_wb_reg) begin
      // One word per cycle keeps the bank single-ported
      ro_data_reg <= {ro_data_reg[47:0], 16'h0000};
      ro_wb_idx   <= ro_wb_idx + 3'h1;
      ro_wb_reg   <= ro_wb_idx != 3'h5;
    end
  end

  assign pif.hw_we    = ro_wb_reg;
  assign pif.hw_idx   = ro_wb_idx;
  assign pif.hw_wdata = ro_data_reg[63:48];

  // flash contents unusable while reading once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pflash_read_invalid <= 1'b0;
    end else begin
      pflash_read_invalid <= state_reg == FVR_RO_RD && !rd_done;
    end
  end

  // Read data registered in the setup phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (acc_setup && !pwrite) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        `FVR_STAT_OFS: begin
          prdata[`FVR_COMMAND_COMPLETE_FLAG_BIT]   <= command_complete_flag;
          prdata[`FVR_ACCESS_ERROR_FLAG_BIT] <= access_error_flag;
          prdata[`FVR_PROTECTION_VIOLATION_FLAG_BIT] <= protection_violation_flag;
          prdata[`FVR_ERR_BIT]    <= error_status_bit;
          prdata[`FVR_UNCORR_BIT] <= uncorrectable_status_bit;
        end
        `FVR_INDEX_OFS: prdata[2:0] <= parameter_word_index;
        `FVR_WORD_OFS: begin
          if (parameter_word_index < 3'(`FVR_WORDS))
            prdata[15:0] <= pif.words[parameter_word_index];
        end
        `FVR_CFG_OFS:     prdata[3:0]  <= cfg_reg;
        `FVR_PROT_LO_OFS: prdata[17:0] <= prot_lo_reg;
        `FVR_PROT_HI_OFS: prdata[17:0] <= prot_hi_reg;
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== fvr_regs.svh
// Register offsets, field positions, reset values and codes of the sequencer
`ifndef FVR_REGS_SVH
`define FVR_REGS_SVH

`define FVR_STAT_OFS     8'h00
`define FVR_INDEX_OFS    8'h04
`define FVR_WORD_OFS     8'h08
`define FVR_CFG_OFS      8'h0C
`define FVR_PROT_LO_OFS  8'h10
`define FVR_PROT_HI_OFS  8'h14

`define FVR_COMMAND_COMPLETE_FLAG_BIT     7
`define FVR_ACCESS_ERROR_FLAG_BIT   5
`define FVR_PROTECTION_VIOLATION_FLAG_BIT   4
`define FVR_ERR_BIT      1
`define FVR_UNCORR_BIT   0

`define FVR_CFG_EV_BIT   0
`define FVR_CFG_RO_BIT   1
`define FVR_CFG_PG_BIT   2
`define FVR_CFG_PEN_BIT  3
`define FVR_CFG_RST      4'h7

`define FVR_CMD_EVSEC    8'h03
`define FVR_CMD_RDONCE   8'h04
`define FVR_CMD_PGM      8'h06
`define FVR_IX_EVSEC     3'h2
`define FVR_IX_RDONCE    3'h1
`define FVR_IX_PGM       3'h5

`define FVR_PF_FIRST     24'hFE0000
`define FVR_PF_END       25'h1000000
`define FVR_ONCE_MAX     16'h0007
`define FVR_ERASED       64'hFFFF_FFFF_FFFF_FFFF
`define FVR_WORDS        6

`endif

// ===== fvr_pkg.sv
// Types shared by the sequencer and its parameter word bank
package fvr_pkg;

  typedef enum logic [2:0] {
    FVR_IDLE  = 3'b000,
    FVR_CHECK = 3'b001,
    FVR_EV_RD = 3'b010,
    FVR_RO_RD = 3'b011,
    FVR_PG_WR = 3'b100,
    FVR_PG_VF = 3'b101,
    FVR_DONE  = 3'b110
  } fvr_state_t;

  typedef enum logic [1:0] {
    FVR_OP_READ  = 2'b00,
    FVR_OP_ONCE  = 2'b01,
    FVR_OP_PROG  = 2'b10
  } fvr_op_t;

  typedef logic [15:0] fvr_word_t;

endpackage

// ===== fvr_param_if.sv
// Parameter word bank access between sequencer and bank
`timescale 1ns/1ps
interface fvr_param_if;
  import fvr_pkg::*;
  logic      sw_we;
  logic [2:0] sw_idx;
  fvr_word_t sw_wdata;
  logic      hw_we;
  logic [2:0] hw_idx;
  fvr_word_t hw_wdata;
  fvr_word_t words [0:5];

  modport bank (input sw_we, sw_idx, sw_wdata, hw_we, hw_idx, hw_wdata,
                output words);
  modport ctrl (output sw_we, sw_idx, sw_wdata, hw_we, hw_idx, hw_wdata,
                input words);
endinterface

// ===== fvr_param_bank.sv
// Six 16-bit command parameter words, written by software or sequencer
`timescale 1ns/1ps
`include "fvr_regs.svh"
module fvr_param_bank
  import fvr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Word access
  fvr_param_if.bank pif
);

  for (genvar i = 0; i < `FVR_WORDS; i++) begin : g_word
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        pif.words[i] <= 16'h0000;
      end else if (pif.hw_we && pif.hw_idx == 3'(i)) begin
        // Sequencer results take priority over a stray software write
        pif.words[i] <= pif.hw_wdata;
      end else if (pif.sw_we && pif.sw_idx == 3'(i)) begin
        pif.words[i] <= pif.sw_wdata;
      end
    end
  end

endmodule

// ===== fvr_sequencer_checker.sv
// Assertions on the sequencer's flash array port
`timescale 1ns/1ps
module fvr_sequencer_checker
  import fvr_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Array port
  input wire logic        arr_req,
  input wire fvr_op_t     arr_op,
  input wire logic [23:0] arr_addr,
  input wire logic        arr_ack,
  input wire logic        pflash_read_invalid
);
  logic [23:0] pg_addr_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge ref_clk)
    if (arr_ack && arr_op == FVR_OP_PROG) pg_addr_reg <= arr_addr;

  a_req_holds: assert property (
    arr_req && !arr_ack |=> arr_req && $stable(arr_addr) && $stable(arr_op))
    else $error("array request changed early");
  a_ack_ends_req: assert property (
    arr_req && arr_ack |=> !arr_req || arr_addr != $past(arr_addr) ||
    arr_op != $past(arr_op))
    else $error("array request kept after answer");
  a_phrase_aligned: assert property (
    arr_req |-> arr_addr[2:0] == 3'h0)
    else $error("misaligned array access");
  a_pf_window: assert property (
    arr_req && arr_op != FVR_OP_ONCE |-> arr_addr >= 24'hFE0000)
    else $error("array access outside flash");
  a_once_range: assert property (
    arr_req && arr_op == FVR_OP_ONCE |-> arr_addr <= 24'h000038)
    else $error("once index out of range");
  a_once_guard: assert property (
    arr_req && arr_ack && arr_op == FVR_OP_ONCE |-> pflash_read_invalid)
    else $error("flash reads not guarded");
  a_verify_follows: assert property (
    arr_req && arr_ack && arr_op == FVR_OP_PROG |-> ##[1:3]
    (arr_req && arr_op == FVR_OP_READ && arr_addr == pg_addr_reg))
    else $error("no read back after program");
  a_once_last: assert property (
    arr_req && arr_ack && arr_op == FVR_OP_ONCE |=> !arr_req [*4])
    else $error("extra access after once read");
endmodule

bind fvr_sequencer fvr_sequencer_checker fvr_sequencer_checker_inst (
  .ref_clk, .rst_n, .arr_req, .arr_op, .arr_addr, .arr_ack,
  .pflash_read_invalid
);

// ===== fvr_flash_model.sv
// Behavioural flash array answering the sequencer
`timescale 1ns/1ps
module fvr_flash_model
  import fvr_pkg::*;
(
  // Array port
  input wire logic        ref_clk,
  input wire logic        arr_req,
  input wire fvr_op_t     arr_op,
  input wire logic [23:0] arr_addr,
  input wire logic [63:0] arr_wdata,
  output logic            arr_ack,
  output logic [63:0]     arr_rdata,
  output logic            arr_rd_err,
  output logic            arr_rd_noncorr,
  // Fault and pace control
  input wire logic [1:0]  err_mode,
  input wire logic        slow
);
  logic [63:0] pf_mem [logic [23:0]];
  logic [63:0] once_mem [8];
  logic [63:0] old;
  logic [1:0]  wait_cnt = 2'h0;

  initial begin
    arr_ack = 1'b0;
    arr_rdata = 64'h0;
    arr_rd_err = 1'b0;
    arr_rd_noncorr = 1'b0;
    for (int i = 0; i < 8; i++)
      for (int k = 0; k < 4; k++)
        once_mem[i][63 - 16 * k -: 16] = 16'hC000 | 16'(i * 16 + k);
  end

  always @(posedge ref_clk) begin
    if (arr_req && !arr_ack && wait_cnt == 2'h0) begin
      old = pf_mem.exists(arr_addr) ? pf_mem[arr_addr] : 64'hFFFFFFFFFFFFFFFF;
      arr_ack <= 1'b1;
      wait_cnt <= slow ? 2'h3 : 2'h0;
      arr_rd_err <= err_mode[1];
      arr_rd_noncorr <= err_mode[0];
      // erased is all ones, program only clears bits
      if (arr_op == FVR_OP_PROG)
        pf_mem[arr_addr] = old & arr_wdata;
      arr_rdata <= arr_op == FVR_OP_ONCE ? once_mem[arr_addr[5:3]] : old;
    end else begin
      arr_ack <= 1'b0;
      arr_rd_err <= 1'b0;
      arr_rd_noncorr <= 1'b0;
      // Released data flips every cycle, so it holds its stale value every second cycle
      arr_rdata <= ~arr_rdata;
      if (arr_req && !arr_ack)
        wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule

// ===== fvr_sequencer_tb.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module fvr_sequencer_tb
  import fvr_pkg::*;
;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
  } fvr_note_t;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [1:0]  err_mode = 2'h0;
  logic        slow    = 1'b0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, arr_req, arr_ack;
  logic        arr_rd_err, arr_rd_noncorr, pflash_read_invalid;
  fvr_op_t     arr_op;
  logic [23:0] arr_addr;
  logic [63:0] arr_wdata, arr_rdata, d;
  fvr_note_t   rd_note;
  fvr_note_t   notes [$];
  logic [87:0] pgm_notes [$];
  int          checked    = 0;
  int          mismatches = 0;

  always #5 ref_clk = ~ref_clk;

  fvr_sequencer fvr_sequencer_inst (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .arr_req, .arr_op, .arr_addr, .arr_wdata, .arr_ack,
    .arr_rdata, .arr_rd_err, .arr_rd_noncorr, .pflash_read_invalid);
  fvr_flash_model fvr_flash_model_inst (
    .ref_clk, .arr_req, .arr_op, .arr_addr, .arr_wdata, .arr_ack,
    .arr_rdata, .arr_rd_err, .arr_rd_noncorr, .err_mode, .slow);

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pg(input logic [87:0] got, input logic [87:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v,
                     input logic [31:0] m = 32'hFFFFFFFF);
    if (!wr) notes.push_back('{v, m});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? v : $urandom;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic cmd(input logic [2:0] ix, input logic [15:0] w0, w1,
                     input logic [63:0] dat, input logic [7:0] st);
    logic [15:0] w [6];
    int n;
    w = '{w0, w1, dat[63:48], dat[47:32], dat[31:16], dat[15:0]};
    if (w0[15:8] == 8'h06 && st[5:4] == 2'h0)
      pgm_notes.push_back({w0[7:0], w1, dat});
    for (int i = 0; i <= int'(ix); i++) begin
      apb(1'b1, 8'h04, 32'(i));
      apb(1'b1, 8'h08, {16'h0, w[i]});
    end
    apb(1'b1, 8'h00, 32'h80);
    n = 0;
    do begin
      apb(1'b0, 8'h00, 32'h0, 32'h0);
      n++;
    end while (rdat[7] !== 1'b1 && n < 40);
    apb(1'b0, 8'h00, {24'h0, st}, 32'hB3);
    apb(1'b1, 8'h00, 32'h30);
  endtask

  always @(posedge ref_clk) begin
    if ((psel && penable && pready && !pwrite) === 1'b1) begin
      rd_note = notes.pop_front();
      if (rd_note.m != 32'h0)
        cmp_rd(prdata & rd_note.m, rd_note.e & rd_note.m);
    end
    // Unmapped offsets answer with a slave error
    if ((psel && penable) === 1'b1)
      cmp_rd({31'h0, pslverr}, {31'h0, paddr > 8'h14 || paddr[1:0] != 2'h0});
    if ((arr_req && arr_ack && arr_op == FVR_OP_PROG) === 1'b1)
      cmp_pg({arr_addr, arr_wdata},
             pgm_notes.size() > 0 ? pgm_notes.pop_front() : 88'h0);
  end

  initial begin
    void'($urandom(32));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, 8'h00, 32'h80, 32'hB3);
    apb(1'b0, 8'h0C, 32'h7, 32'hF);
    apb(1'b0, 8'h18, 32'h0);
    d = {$urandom, $urandom};
    slow <= 1'b1;
    cmd(3'h5, 16'h06FE, 16'h0100, d, 8'h80);
    cmd(3'h2, 16'h03FE, 16'h00F8, {16'h3, 48'h0}, 8'h83);
    cmd(3'h2, 16'h03FE, 16'h0800, {16'h4, 48'h0}, 8'h80);
    slow <= 1'b0;
    cmd(3'h2, 16'h03FF, 16'hFFF8, {16'h1, 48'h0}, 8'h80);
    cmd(3'h2, 16'h03FF, 16'hFFF8, {16'h2, 48'h0}, 8'hA0);
    cmd(3'h1, 16'h03FE, 16'h0800, d, 8'hA0);
    cmd(3'h2, 16'h03FE, 16'h0804, {16'h1, 48'h0}, 8'hA0);
    cmd(3'h2, 16'h037F, 16'h0000, {16'h1, 48'h0}, 8'hA0);
    cmd(3'h5, 16'h06FE, 16'h0204, d, 8'hA0);
    cmd(3'h5, 16'h067F, 16'h0200, d, 8'hA0);
    cmd(3'h4, 16'h06FE, 16'h0200, d, 8'hA0);
    cmd(3'h2, 16'h0400, 16'h0000, d, 8'hA0);
    cmd(3'h1, 16'h0400, 16'h0008, d, 8'hA0);
    apb(1'b1, 8'h0C, 32'h0);
    cmd(3'h2, 16'h03FE, 16'h0800, {16'h1, 48'h0}, 8'hA0);
    cmd(3'h1, 16'h0400, 16'h0000, d, 8'hA0);
    cmd(3'h5, 16'h06FE, 16'h0300, d, 8'hA0);
    apb(1'b1, 8'h0C, 32'hF);
    apb(1'b1, 8'h10, 32'h20200);
    apb(1'b1, 8'h14, 32'h20200);
    cmd(3'h5, 16'h06FE, 16'h0200, d, 8'h90);
    cmd(3'h5, 16'h06FE, 16'h0208, ~d, 8'h80);
    apb(1'b1, 8'h0C, 32'h7);
    for (int p = 0; p < 8; p++) begin
      cmd(3'h1, 16'h0400, 16'(p), d, 8'h80);
      for (int k = 2; k < 6; k++) begin
        apb(1'b1, 8'h04, 32'(k));
        apb(1'b0, 8'h08, 32'hC000 | 32'(p * 16 + k - 2), 32'hFFFF);
      end
    end
    err_mode <= 2'h2;
    cmd(3'h2, 16'h03FE, 16'h0800, {16'h2, 48'h0}, 8'h82);
    err_mode <= 2'h3;
    cmd(3'h1, 16'h0400, 16'h0003, d, 8'h83);
    err_mode <= 2'h2;
    cmd(3'h5, 16'h06FE, 16'h0400, d, 8'h82);
    err_mode <= 2'h0;
    summarize();
  end

  initial begin
    #200us;
    mismatches++;
    summarize();
  end
endmodule
